// File: rtl/acr_pkg.sv
// Package: register map, field layout, reset values and timing of the converter control block
package acr_pkg;
  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  // Each register takes one word: the byte address is four times its index
  localparam logic [3:0] idx_enable_sleep_control = 4'h0;
  localparam logic [3:0] idx_clock_prescale = 4'h1;
  localparam logic [3:0] idx_timebase_reference = 4'h2;
  localparam logic [3:0] idx_status = 4'h3;
  localparam logic [3:0] idx_command = 4'h4;
  localparam logic [11:0] addr_enable_sleep_control = 12'h000;
  localparam logic [11:0] addr_clock_prescale = 12'h004;
  localparam logic [11:0] addr_timebase_reference = 12'h008;
  localparam logic [11:0] addr_status = 12'h00C;
  localparam logic [11:0] addr_command = 12'h010;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int bit_enable = 0;
  localparam int bit_low_latency_keep_on = 5;
  localparam int bit_run_in_standby = 7;
  localparam int lsb_clock_divider_select = 0;
  localparam int lsb_reference_select = 0;
  localparam int lsb_timebase = 3;
  localparam int bit_converter_busy_flag = 0;
  localparam int bit_command_start = 0;
  localparam logic [7:0] mask_enable_sleep_control = 8'hA1;
  localparam logic [7:0] mask_clock_prescale = 8'h0F;
  localparam logic [7:0] mask_timebase_reference = 8'hFF;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] rst_enable_sleep_control = 8'h00;
  localparam logic [7:0] rst_clock_prescale = 8'h00;
  localparam logic [7:0] rst_timebase_reference = 8'h00;
  // ----------------------------------------------------------------
  // Reference codes
  // ----------------------------------------------------------------
  localparam logic [2:0] ref_supply = 3'h0;
  localparam logic [2:0] ref_external = 3'h2;
  localparam logic [2:0] ref_internal_1024 = 3'h4;
  localparam logic [2:0] ref_internal_4096 = 3'h7;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int ref_init_time_us = 60;
  localparam int converter_cycles_per_conversion = 13;
  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    acr_idle = 5'b00001,
    acr_power_up = 5'b00010,
    acr_guard = 5'b00100,
    acr_convert = 5'b01000,
    acr_finish = 5'b10000
  } acr_state_t;
endpackage

// File: rtl/acr_clock_divider.sv
// Prescaler that derives the converter clock enable from the peripheral clock
`timescale 1ns/1ps
module acr_clock_divider (
  input wire logic pclk, // Peripheral clock
  input wire logic presetn, // Asynchronous reset, active low
  input wire logic clk_en, // Freezes state while low
  input wire logic run, // Divider runs while high
  input wire logic [3:0] clock_divider_select, // Division code
  output logic converter_tick, // One-cycle pulse per converter clock period
  output logic converter_clock // Divided clock level
);
  typedef struct packed {
    logic [5:0] count;
    logic level;
  } acr_div_t;

  acr_div_t cur;
  acr_div_t next_cur;

  // Half period in peripheral cycles, minus one
  function automatic logic [5:0] half_minus_one(input logic [3:0] code);
    logic [6:0] ratio;
    ratio = 7'h00;
    if (code < 4'h8)
      ratio = 7'(({3'h0, code} + 7'h01) * 7'h02);
    else if (code < 4'hC)
      ratio = 7'(({3'h0, code} - 7'h03) * 7'h04);
    else
      ratio = 7'(({3'h0, code} - 7'h07) * 7'h08);
    half_minus_one = 6'((ratio >> 1) - 7'h01);
  endfunction

  always_comb
  begin
    next_cur = cur;
    converter_tick = 1'b0;
    if (!run)
    begin
      next_cur.count = 6'h00;
      next_cur.level = 1'b0;
    end
    else if (cur.count >= half_minus_one(clock_divider_select))
    begin
      next_cur.count = 6'h00;
      next_cur.level = !cur.level;
      converter_tick = cur.level;
    end
    else
      next_cur.count = cur.count + 6'h01;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cur <= '0;
    else if (clk_en)
      cur <= next_cur;
  end

  assign converter_clock = cur.level;
endmodule // acr_clock_divider

// File: rtl/acr_guard_timer.sv
// Guard-delay counter in whole microsecond timebase periods
`timescale 1ns/1ps
module acr_guard_timer #(
  parameter int delay_width = 7 // Width of the microsecond count
) (
  input wire logic pclk, // Peripheral clock
  input wire logic presetn, // Asynchronous reset, active low
  input wire logic clk_en, // Freezes state while low
  input wire logic [4:0] timebase, // Peripheral cycles per microsecond, minus one
  input wire logic load, // Start a new delay
  input wire logic [delay_width-1:0] delay_us, // Delay length in microseconds
  output logic running // High while the delay has not expired
);
  typedef struct packed {
    logic [4:0] cycles;
    logic [delay_width-1:0] us_left;
  } acr_guard_t;

  acr_guard_t cur;
  acr_guard_t next_cur;

  always_comb
  begin
    next_cur = cur;
    if (load)
    begin
      next_cur.cycles = 5'h00;
      next_cur.us_left = delay_us;
    end
    else if (cur.us_left != '0)
    begin
      // Timebase code n gives n+1 cycles per period so a zero code still advances
      if (cur.cycles >= timebase)
      begin
        next_cur.cycles = 5'h00;
        next_cur.us_left = cur.us_left - 1'b1;
      end
      else
        next_cur.cycles = cur.cycles + 5'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cur <= '0;
    else if (clk_en)
      cur <= next_cur;
  end

  assign running = (cur.us_left != '0);
endmodule // acr_guard_timer

// File: rtl/acr_adc_control.sv
// Top of the converter control block: APB registers, sequencing, power and reference control
`timescale 1ns/1ps
// ----------------------------------------------------------------
// How it works
// - With run in standby clear the converter stops in standby, but only after finishing a running conversion.
// - With run in standby set the converter runs in standby and requests the main clock when triggered.
// - With low latency clear the analog modules are powered only when a conversion starts.
// - With low latency set the selected analog modules stay powered continuously, except in standby with run in standby clear.
// - Low latency never keeps the clock source running while no conversion is active.
// - Bit 0 of the first control register enables the converter and resets to 0.
// - The 4-bit divider code divides the peripheral clock by 2..16, 20..32 or 40..64.
// - The 5-bit timebase field gives the peripheral cycles making up at least one microsecond.
// - The 3-bit reference code picks the supply, the external input or one of four internal references.
// - After a change to an internal reference a 60 us start-up interval passes before it is used.
// - With low latency and run in standby both set, all conversion modules stay powered in standby.
// - The busy flag clears only after the conversion and all settling delays are over.
// ----------------------------------------------------------------
module acr_adc_control #(
  parameter int ref_init_us = acr_pkg::ref_init_time_us, // Reference start-up time in microseconds
  parameter int conv_cycles = acr_pkg::converter_cycles_per_conversion // Converter clocks per conversion
) (
  input wire logic pclk, // Peripheral clock, 100 MHz
  input wire logic presetn, // Asynchronous reset, active low
  input wire logic clk_en, // Freezes all state while low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [3:0] pstrb, // APB byte strobes
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic start_trigger, // Conversion start event
  input wire logic standby_sleep, // System is in standby sleep
  input wire logic core_done, // Analog core reports end of conversion
  input wire logic main_clock_ready, // Main clock source is running
  output logic main_clock_request, // Request main clock for a conversion
  output logic analog_power_on, // Power to the analog modules
  output logic reference_enable, // Enable the selected internal reference
  output logic [2:0] reference_select_out, // Reference choice to the analog side
  output logic converter_clock, // Divided converter clock
  output logic core_start, // One-cycle start pulse to the analog core
  output logic converter_busy_flag // Conversion or settling in progress
);
  typedef struct packed {
    logic [7:0] enable_sleep_control;
    logic [7:0] clock_prescale;
    logic [7:0] timebase_reference;
    acr_pkg::acr_state_t state;
    logic [7:0] conv_count;
    logic pending;
    logic [31:0] rdata;
    logic start_pulse;
  } acr_top_t;

  acr_top_t cur;
  acr_top_t next_cur;
  logic converter_tick;
  logic guard_running;
  logic guard_load;
  logic access;
  logic wr;
  logic enable;
  logic run_in_standby;
  logic low_latency_keep_on;
  logic [2:0] reference_select;
  logic [2:0] next_reference_select;
  logic stalled;
  logic converting;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic is_internal_ref(input logic [2:0] code);
    is_internal_ref = (code >= acr_pkg::ref_internal_1024) && (code <= acr_pkg::ref_internal_4096);
  endfunction

  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] data,
                                       input logic lane, input logic [7:0] mask);
    merge = lane ? (data & mask) : old;
  endfunction

  assign enable = cur.enable_sleep_control[acr_pkg::bit_enable];
  assign run_in_standby = cur.enable_sleep_control[acr_pkg::bit_run_in_standby];
  assign low_latency_keep_on = cur.enable_sleep_control[acr_pkg::bit_low_latency_keep_on];
  assign reference_select = cur.timebase_reference[acr_pkg::lsb_reference_select +: 3];
  assign converting = (cur.state != acr_pkg::acr_idle);
  // Standby without run-in-standby stops new work; running conversions finish first
  assign stalled = standby_sleep && !run_in_standby;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  assign access = psel && penable;
  assign wr = access && pwrite;
  assign pready = 1'b1;
  assign pslverr = access && (paddr[1:0] != 2'b00 || paddr > acr_pkg::addr_command);
  assign prdata = cur.rdata;

  always_comb
  begin
    next_reference_select = reference_select;
    if (wr && paddr == acr_pkg::addr_timebase_reference && pstrb[0])
      next_reference_select = pwdata[acr_pkg::lsb_reference_select +: 3];
  end
  // Any write that moves to an internal reference restarts the start-up interval
  assign guard_load = (next_reference_select != reference_select) && is_internal_ref(next_reference_select);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_cur = cur;
    next_cur.start_pulse = 1'b0;
    if (wr && paddr == acr_pkg::addr_enable_sleep_control)
      next_cur.enable_sleep_control = merge(cur.enable_sleep_control, pwdata[7:0], pstrb[0],
                                            acr_pkg::mask_enable_sleep_control);
    if (wr && paddr == acr_pkg::addr_clock_prescale)
      next_cur.clock_prescale = merge(cur.clock_prescale, pwdata[7:0], pstrb[0],
                                      acr_pkg::mask_clock_prescale);
    if (wr && paddr == acr_pkg::addr_timebase_reference)
      next_cur.timebase_reference = merge(cur.timebase_reference, pwdata[7:0], pstrb[0],
                                          acr_pkg::mask_timebase_reference);
    // Read data is registered at the setup cycle so it stands for the access cycle
    if (psel && !penable && !pwrite)
    begin
      next_cur.rdata = 32'h0000_0000;
      case (paddr)
        acr_pkg::addr_enable_sleep_control: next_cur.rdata[7:0] = cur.enable_sleep_control;
        acr_pkg::addr_clock_prescale: next_cur.rdata[7:0] = cur.clock_prescale;
        acr_pkg::addr_timebase_reference: next_cur.rdata[7:0] = cur.timebase_reference;
        acr_pkg::addr_status: next_cur.rdata[acr_pkg::bit_converter_busy_flag] = converter_busy_flag;
        default: next_cur.rdata = 32'h0000_0000;
      endcase
    end
    case (cur.state)
      acr_pkg::acr_idle:
      begin
        next_cur.conv_count = 8'h00;
        if (cur.pending && enable && !stalled)
          next_cur.state = acr_pkg::acr_power_up;
      end
      acr_pkg::acr_power_up:
      begin
        // Clock start-up delay is paid here even under low latency
        if (!enable)
          next_cur.state = acr_pkg::acr_idle;
        else if (main_clock_ready)
          next_cur.state = acr_pkg::acr_guard;
      end
      acr_pkg::acr_guard:
      begin
        if (!enable)
          next_cur.state = acr_pkg::acr_idle;
        else if (!guard_running && !guard_load)
        begin
          next_cur.state = acr_pkg::acr_convert;
          next_cur.pending = 1'b0;
          next_cur.start_pulse = 1'b1;
        end
      end
      acr_pkg::acr_convert:
      begin
        // Ends on the core's report or after the nominal number of converter clocks
        if (core_done || cur.conv_count >= 8'(conv_cycles))
          next_cur.state = acr_pkg::acr_finish;
        else if (converter_tick)
          next_cur.conv_count = cur.conv_count + 8'h01;
      end
      acr_pkg::acr_finish:
      begin
        if (!guard_running && !guard_load)
          next_cur.state = acr_pkg::acr_idle;
      end
      default: next_cur.state = acr_pkg::acr_idle;
    endcase
    // A trigger while busy is held once; one on the start edge beats the clear so it is not lost
    if (enable && (start_trigger ||
        (wr && paddr == acr_pkg::addr_command && pstrb[0] && pwdata[acr_pkg::bit_command_start])))
      next_cur.pending = 1'b1;
    if (!enable)
      next_cur.pending = 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cur <= '0;
      cur.enable_sleep_control <= acr_pkg::rst_enable_sleep_control;
      cur.clock_prescale <= acr_pkg::rst_clock_prescale;
      cur.timebase_reference <= acr_pkg::rst_timebase_reference;
      cur.state <= acr_pkg::acr_idle;
    end
    else if (clk_en)
      cur <= next_cur;
  end

  // ----------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------
  acr_clock_divider u_divider (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .run(enable && converting),
    .clock_divider_select(cur.clock_prescale[acr_pkg::lsb_clock_divider_select +: 4]),
    .converter_tick(converter_tick),
    .converter_clock(converter_clock)
  );

  acr_guard_timer #(
    .delay_width(7)
  ) u_guard (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .timebase(cur.timebase_reference[acr_pkg::lsb_timebase +: 5]),
    .load(guard_load),
    .delay_us(7'(ref_init_us)),
    .running(guard_running)
  );

  // ----------------------------------------------------------------
  // Outputs to the analog side
  // ----------------------------------------------------------------
  // Clock requested only while a conversion is under way, never held by low latency
  assign main_clock_request = converting && (run_in_standby || !standby_sleep);
  // Low latency keeps power in standby only with run in standby; otherwise only per conversion
  assign analog_power_on = enable && (converting ||
                           (low_latency_keep_on && (!standby_sleep || run_in_standby)));
  assign reference_enable = analog_power_on && is_internal_ref(reference_select);
  assign reference_select_out = reference_select;
  assign core_start = cur.start_pulse;
  assign converter_busy_flag = converting || guard_running;
endmodule // acr_adc_control

// File: testbench/acr_adc_control_chk.sv
// Checker of the converter control block, bound to its top module
`timescale 1ns/1ps
module acr_adc_control_chk #(
  parameter int ref_init_us = 3 // Reference start-up in microseconds
) (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [3:0] pstrb, // APB strobes
  input wire logic pready, // APB ready
  input wire logic pslverr, // APB error
  input wire logic standby_sleep, // Standby
  input wire logic main_clock_request, // Clock request
  input wire logic analog_power_on, // Analog power
  input wire logic reference_enable, // Reference on
  input wire logic [2:0] reference_select_out, // Reference code
  input wire logic core_start, // Core start
  input wire logic converter_busy_flag // Busy
);
  // ----------------------------------------------------------------
  // Shadow of the control fields, kept from the bus writes
  // ----------------------------------------------------------------
  logic en, ll, rs, fresh, wr, ld;
  logic [2:0] rf;
  int cnt;
  assign wr = psel && penable && pwrite && pready && pstrb[0];
  assign ld = wr && paddr == 12'h008 && pwdata[2] && pwdata[2:0] != rf;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      {en, ll, rs, rf, fresh, cnt} <= '0;
    end
    else
    begin
      if (wr && paddr == 12'h000) {rs, ll, en} <= {pwdata[7], pwdata[5], pwdata[0]};
      if (wr && paddr == 12'h008) rf <= pwdata[2:0];
      // Timer start may lag the write by one edge, so the first cycle is not judged
      fresh <= ld;
      cnt <= ld ? ref_init_us * (int'(pwdata[7:3]) + 1) : (cnt != 0 ? cnt - 1 : 0);
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_standby_hold: assert property (standby_sleep && !rs |-> !main_clock_request) else $error("clock request in standby");
  a_clock_request: assert property (core_start && (rs || !standby_sleep) |-> main_clock_request) else $error("no clock request");
  a_idle_power: assert property (!converter_busy_flag && !ll |-> !analog_power_on) else $error("power while idle");
  a_keep_power: assert property (en && ll && (rs || !standby_sleep) |-> analog_power_on) else $error("power dropped");
  a_idle_clock: assert property (!converter_busy_flag |-> !main_clock_request) else $error("clock kept running");
  a_power_gate: assert property (!en |-> !analog_power_on) else $error("power while disabled");
  a_start_pulse: assert property (core_start |-> en ##1 !core_start) else $error("bad start pulse");
  a_ref_route: assert property (reference_select_out == rf && reference_enable == (analog_power_on && rf[2]))
    else $error("reference routing wrong");
  a_guard_busy: assert property (cnt != 0 && !fresh |-> converter_busy_flag) else $error("guard cut short");
  a_bad_addr: assert property (psel && penable && (paddr > 12'h010 || paddr[1:0] != 2'b00) |-> pslverr)
    else $error("no error on unmapped access");
  a_good_addr: assert property (psel && penable && paddr <= 12'h010 && paddr[1:0] == 2'b00 |-> !pslverr && pready)
    else $error("mapped access refused");
endmodule // acr_adc_control_chk
bind acr_adc_control acr_adc_control_chk #(.ref_init_us(ref_init_us)) acr_adc_control_chk_inst (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .pready(pready), .pslverr(pslverr), .standby_sleep(standby_sleep), .main_clock_request(main_clock_request),
  .analog_power_on(analog_power_on), .reference_enable(reference_enable),
  .reference_select_out(reference_select_out), .core_start(core_start), .converter_busy_flag(converter_busy_flag));

// File: testbench/acr_core_model.sv
// Model of the analog core and the main clock source
`timescale 1ns/1ps
module acr_core_model #(
  parameter int clk_delay = 4, // Clock start-up cycles in standby
  parameter int done_delay = 5 // Conversion cycles of the core
) (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset, active low
  input wire logic standby_sleep, // Standby
  input wire logic main_clock_request, // Clock request
  input wire logic core_start, // Start pulse
  input wire logic done_en, // Core answers when high
  output logic main_clock_ready, // Clock running
  output logic core_done // End of conversion
);
  int rc, dc;
  // In standby the clock starts only on request and stops with it, so a start-up delay is always seen
  assign main_clock_ready = !standby_sleep || rc == clk_delay;
  assign core_done = dc == 1;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rc <= 0;
      dc <= 0;
    end
    else
    begin
      rc <= main_clock_request ? (rc < clk_delay ? rc + 1 : rc) : 0;
      dc <= (core_start && done_en) ? done_delay : (dc != 0 ? dc - 1 : 0);
    end
  end
endmodule // acr_core_model

// File: testbench/acr_adc_control_test.sv
// Self-checking testbench of the converter control block
`timescale 1ns/1ps
module acr_adc_control_test;
  logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, start_trigger, standby_sleep;
  logic core_done, main_clock_ready, main_clock_request, analog_power_on, reference_enable;
  logic converter_clock, core_start, converter_busy_flag, done_en;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [3:0] pstrb;
  logic [2:0] reference_select_out;
  logic [31:0] exp_q[$];
  int miscompares, n_checks, cyc, starts, s;
  acr_adc_control #(.ref_init_us(3), .conv_cycles(8)) acr_adc_control_inst (.pclk(pclk), .presetn(presetn),
    .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .start_trigger(start_trigger),
    .standby_sleep(standby_sleep), .core_done(core_done), .main_clock_ready(main_clock_ready),
    .main_clock_request(main_clock_request), .analog_power_on(analog_power_on),
    .reference_enable(reference_enable), .reference_select_out(reference_select_out),
    .converter_clock(converter_clock), .core_start(core_start), .converter_busy_flag(converter_busy_flag));
  acr_core_model acr_core_model_inst (.pclk(pclk), .presetn(presetn), .standby_sleep(standby_sleep),
    .main_clock_request(main_clock_request), .core_start(core_start), .done_en(done_en),
    .main_clock_ready(main_clock_ready), .core_done(core_done));
  always #5 pclk = ~pclk;
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task results;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task cmp(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] st);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata, pstrb} <= {1'b1, 1'b0, w, a, d, st};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    {psel, penable} <= 2'b00;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 4'hF);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    xfer(1'b0, a, 32'h0000_0000, 4'hF);
  endtask
  task trig;
    @(posedge pclk);
    start_trigger <= 1'b1;
    @(posedge pclk);
    start_trigger <= 1'b0;
  endtask
  task wait_idle;
    for (int i = 0; i < 3000 && converter_busy_flag !== 1'b0; i++) @(posedge pclk);
  endtask
  task period(input int c);
    int k, n, c1;
    logic p;
    k = 0;
    n = 0;
    c1 = 0;
    p = converter_clock;
    while (n < 2 && k < 3000)
    begin
      @(posedge pclk);
      k++;
      if (n == 1) c1++;
      if (converter_clock === 1'b1 && p === 1'b0) n++;
      p = converter_clock;
    end
    cmp(c1, c < 8 ? 2 * (c + 1) : (c < 12 ? 20 + 4 * (c - 8) : 40 + 8 * (c - 12)));
  endtask
  // ----------------------------------------------------------------
  // Result watcher and time limit
  // ----------------------------------------------------------------
  always @(posedge pclk)
  begin
    if (core_start === 1'b1) starts++;
    if (psel && penable && !pwrite && pready === 1'b1 && exp_q.size() > 0) cmp(prdata, exp_q.pop_front());
    cyc++;
    if (cyc == 50000)
    begin
      miscompares++;
      results;
    end
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    {pclk, presetn, psel, penable, pwrite, start_trigger, standby_sleep, done_en} = '0;
    {paddr, pwdata, pstrb, miscompares, n_checks, cyc, starts} = '0;
    clk_en = 1'b1;
    r = $urandom(32'h1daf);
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 5; i++) rd(12'(4 * i), 32'h0000_0000);
    wr(12'h000, 32'hFFFF_FFFF);
    wr(12'h004, 32'hFFFF_FFFF);
    wr(12'h008, 32'hFFFF_FFFF);
    rd(12'h000, 32'h0000_00A1);
    rd(12'h004, 32'h0000_000F);
    rd(12'h008, 32'h0000_00FF);
    rd(12'h00C, 32'h0000_0001);
    r = $urandom;
    xfer(1'b1, 12'h004, r, 4'h0);
    wr(12'h014, r);
    rd(12'h014, 32'h0000_0000);
    rd(12'h004, 32'h0000_000F);
    wait_idle;
    rd(12'h00C, 32'h0000_0000);
    wr(12'h000, 32'h0000_0000);
    for (int c = 0; c < 8; c++)
    begin
      wr(12'h008, 32'(8'h18 | c));
      #1;
      cmp(reference_select_out, 32'(c));
      if (c >= 4) rd(12'h00C, 32'h0000_0001);
      wait_idle;
    end
    wr(12'h008, 32'h0000_0000);
    wr(12'h000, 32'h0000_0001);
    for (int c = 0; c < 16; c++)
    begin
      wr(12'h004, 32'(c));
      wr(12'h010, 32'h0000_0001);
      period(c);
      wait_idle;
    end
    done_en <= 1'b1;
    standby_sleep <= 1'b1;
    s = starts;
    trig;
    repeat (60) @(posedge pclk);
    cmp(starts, s);
    standby_sleep <= 1'b0;
    for (int i = 0; i < 200 && starts == s; i++) @(posedge pclk);
    cmp(starts, s + 1);
    wait_idle;
    wr(12'h000, 32'h0000_0081);
    standby_sleep <= 1'b1;
    trig;
    for (int i = 0; i < 100 && main_clock_request !== 1'b1; i++) @(posedge pclk);
    cmp(main_clock_request, 1);
    wait_idle;
    cmp(main_clock_request, 0);
    wr(12'h000, 32'h0000_00A1);
    #1;
    cmp(analog_power_on, 1);
    wr(12'h000, 32'h0000_0021);
    #1;
    cmp(analog_power_on, 0);
    @(posedge pclk);
    standby_sleep <= 1'b0;
    @(posedge pclk);
    #1;
    cmp(analog_power_on, 1);
    wr(12'h000, 32'h0000_0001);
    #1;
    cmp(analog_power_on, 0);
    // Freeze in mid-conversion: the divided clock and the busy state must hold
    @(posedge pclk);
    done_en <= 1'b0;
    wr(12'h010, 32'h0000_0001);
    repeat (40) @(posedge pclk);
    clk_en <= 1'b0;
    @(posedge pclk);
    #1;
    r = 32'(converter_clock);
    repeat (50) @(posedge pclk);
    #1;
    cmp(converter_clock, r);
    cmp(converter_busy_flag, 1);
    @(posedge pclk);
    clk_en <= 1'b1;
    wait_idle;
    cmp(converter_busy_flag, 0);
    results;
  end
endmodule // acr_adc_control_test
